// file: mfp_fault_protect.sv
// Summary of operation
// R1: high-current limit is an 8-bit register, reset 0xa2, code scales to milliamps.
// R2: low-current limit is an 8-bit register, reset 0x48, same scaling.
// R3: monitor upper voltage limit is 8-bit, reset 0xba, volts scaling.
// R4: monitor lower voltage limit is 8-bit, reset 0x4b, same scaling.
// R5: short fault powers bias down when its control is set; resets to 1.
// R6: high-current fault powers bias down when its control is set; resets 0.
// R7: low-current fault powers bias down when its control is set; resets 0.
// R8: overvoltage fault powers bias down when its control is set; resets 0.
// R9: over-temperature fault powers bias down when its control is set; resets 1.
// R10: writing 1 to manual recovery rechecks faults, repowers, then self-clears.
// R11: auto recovery enable lets the bias return by itself; resets 0.
// R12: short detection works only while its disable bit is 0; resets 0.
// R13: high fault when code exceeds high limit, low fault when below low limit.
`timescale 1ns/100ps
`default_nettype none

module mfp_fault_protect (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output var  logic [7:0] regRdata,
  input  wire logic       biasRequest,
  input  wire logic       sampleValid,
  input  wire logic [7:0] biasLoadCode,
  input  wire logic [7:0] monitorCode,
  input  wire logic       shortFaultPin,
  input  wire logic       overvoltagePin,
  input  wire logic       overtempPin,
  output var  logic       biasEnable,
  output var  logic       biasFaultOff,
  output logic            highCurrentFault,
  output logic            lowCurrentFault,
  output logic            monitorHighFault,
  output logic            monitorLowFault
);

  // register file
  logic [7:0] highLimit;
  logic [7:0] lowLimit;
  logic [7:0] upperLimit;
  logic [7:0] lowerLimit;
  logic [7:0] respCtrl;
  logic [7:0] next_highLimit;
  logic [7:0] next_lowLimit;
  logic [7:0] next_upperLimit;
  logic [7:0] next_lowerLimit;
  logic [7:0] next_respCtrl;
  logic [7:0] next_regRdata;

  // synchroniser and fault state
  logic [mfp_pkg::PIN_COUNT-1:0] pinMeta;
  logic [mfp_pkg::PIN_COUNT-1:0] pinSync;
  logic                          next_biasFaultOff;
  logic                          next_biasEnable;
  logic                          shortHit;
  logic                          offRequest;
  logic [7:0]                    faultStatus;

  // true when a write lands on the given offset
  function automatic logic writeTo(input logic we, input logic [7:0] addr, input logic [7:0] ofs);
    writeTo = we && (addr == ofs);
  endfunction

  // a fault counts towards powerdown only when its control bit asks for it
  function automatic logic gated(input logic fault, input logic [7:0] ctrl, input int pos);
    gated = fault && ctrl[pos];
  endfunction

  // measurement comparisons, bias load against current limits
  mfp_limit_check u_loadCheck (
    .mclk        (mclk),
    .resetn      (resetn),
    .sampleValid (sampleValid),
    .code        (biasLoadCode),
    .upperLimit  (highLimit),
    .lowerLimit  (lowLimit),
    .aboveLimit  (highCurrentFault),
    .belowLimit  (lowCurrentFault)
  );

  // monitor channel against its voltage window; reported only, no powerdown
  mfp_limit_check u_monitorCheck (
    .mclk        (mclk),
    .resetn      (resetn),
    .sampleValid (sampleValid),
    .code        (monitorCode),
    .upperLimit  (upperLimit),
    .lowerLimit  (lowerLimit),
    .aboveLimit  (monitorHighFault),
    .belowLimit  (monitorLowFault)
  );

  // analog comparator pins are asynchronous, two flops before use
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= {overtempPin, overvoltagePin, shortFaultPin};
      pinSync <= pinMeta;
    end
  end

  // short detection can be switched off, e.g. for large bypass capacitors at start-up
  assign shortHit = pinSync[mfp_pkg::PIN_SHORT] && !respCtrl[mfp_pkg::BIT_SHORT_DIS];  // [R12]

  // any fault whose powerdown control is set
  assign offRequest = gated(shortHit, respCtrl, mfp_pkg::BIT_OFF_SHORT)                      // [R5]
                   || gated(highCurrentFault, respCtrl, mfp_pkg::BIT_OFF_HIGH)               // [R6]
                   || gated(lowCurrentFault, respCtrl, mfp_pkg::BIT_OFF_LOW)                 // [R7]
                   || gated(pinSync[mfp_pkg::PIN_OV], respCtrl, mfp_pkg::BIT_OFF_OV)         // [R8]
                   || gated(pinSync[mfp_pkg::PIN_OT], respCtrl, mfp_pkg::BIT_OFF_OT);        // [R9]

  // live fault picture for software
  always_comb begin
    faultStatus                         = mfp_pkg::RST_ZERO;
    faultStatus[mfp_pkg::STS_SHORT]     = shortHit;
    faultStatus[mfp_pkg::STS_HIGH_CUR]  = highCurrentFault;
    faultStatus[mfp_pkg::STS_LOW_CUR]   = lowCurrentFault;
    faultStatus[mfp_pkg::STS_OV]        = pinSync[mfp_pkg::PIN_OV];
    faultStatus[mfp_pkg::STS_OT]        = pinSync[mfp_pkg::PIN_OT];
    faultStatus[mfp_pkg::STS_MON_HIGH]  = monitorHighFault;
    faultStatus[mfp_pkg::STS_MON_LOW]   = monitorLowFault;
    faultStatus[mfp_pkg::STS_BIAS_OFF]  = biasFaultOff;
  end

  // register writes; the manual recovery bit clears itself after one cycle
  always_comb begin
    next_highLimit  = highLimit;
    next_lowLimit   = lowLimit;
    next_upperLimit = upperLimit;
    next_lowerLimit = lowerLimit;
    next_respCtrl   = respCtrl;
    next_respCtrl[mfp_pkg::BIT_MAN_RECOV] = 1'b0;                       // [R10]
    if (writeTo(regWrite, regAddr, mfp_pkg::OFS_HIGH_CUR)) begin
      next_highLimit = regWdata;                                         // [R1]
    end
    if (writeTo(regWrite, regAddr, mfp_pkg::OFS_LOW_CUR)) begin
      next_lowLimit = regWdata;                                          // [R2]
    end
    if (writeTo(regWrite, regAddr, mfp_pkg::OFS_MON_UPPER)) begin
      next_upperLimit = regWdata;                                        // [R3]
    end
    if (writeTo(regWrite, regAddr, mfp_pkg::OFS_MON_LOWER)) begin
      next_lowerLimit = regWdata;                                        // [R4]
    end
    // a fresh 1 beats the self-clear, so a request is never lost
    if (writeTo(regWrite, regAddr, mfp_pkg::OFS_RESP_CTRL)) begin
      next_respCtrl = regWdata;                                          // [R10]
    end
  end

  // read data registered from the address of the previous cycle
  always_comb begin
    unique case (regAddr)
      mfp_pkg::OFS_HIGH_CUR:   next_regRdata = highLimit;
      mfp_pkg::OFS_LOW_CUR:    next_regRdata = lowLimit;
      mfp_pkg::OFS_MON_UPPER:  next_regRdata = upperLimit;
      mfp_pkg::OFS_MON_LOWER:  next_regRdata = lowerLimit;
      mfp_pkg::OFS_RESP_CTRL:  next_regRdata = respCtrl;
      mfp_pkg::OFS_FLT_STATUS: next_regRdata = faultStatus;
      default:                 next_regRdata = mfp_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      highLimit  <= mfp_pkg::RST_HIGH_CUR;   // [R1]
      lowLimit   <= mfp_pkg::RST_LOW_CUR;    // [R2]
      upperLimit <= mfp_pkg::RST_MON_UPPER;  // [R3]
      lowerLimit <= mfp_pkg::RST_MON_LOWER;  // [R4]
      respCtrl   <= mfp_pkg::RST_RESP_CTRL;  // [R5] [R9] [R11] [R12]
      regRdata   <= mfp_pkg::RST_ZERO;
    end else begin
      highLimit  <= next_highLimit;
      lowLimit   <= next_lowLimit;
      upperLimit <= next_upperLimit;
      lowerLimit <= next_lowerLimit;
      respCtrl   <= next_respCtrl;
      regRdata   <= next_regRdata;
    end
  end

  // powerdown latch; a fault still present keeps the bias off, so set wins over recovery
  always_comb begin
    next_biasFaultOff = biasFaultOff;
    if (offRequest) begin
      next_biasFaultOff = 1'b1;
    end else if (respCtrl[mfp_pkg::BIT_MAN_RECOV] || respCtrl[mfp_pkg::BIT_AUTO_RECOV]) begin
      next_biasFaultOff = 1'b0;  // [R10] [R11]
    end
    next_biasEnable = biasRequest && !next_biasFaultOff;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      biasFaultOff <= 1'b0;
      biasEnable   <= 1'b0;
    end else begin
      biasFaultOff <= next_biasFaultOff;
      biasEnable   <= next_biasEnable;
    end
  end

  property p_highLimitReset;
    @(posedge mclk) disable iff (!resetn) $rose(resetn) |-> highLimit == mfp_pkg::RST_HIGH_CUR;
  endproperty
  a_highLimitReset: assert property (p_highLimitReset) else $error("high-current limit reset wrong"); // [R1]

  property p_lowLimitReset;
    @(posedge mclk) disable iff (!resetn) $rose(resetn) |-> lowLimit == mfp_pkg::RST_LOW_CUR;
  endproperty
  a_lowLimitReset: assert property (p_lowLimitReset) else $error("low-current limit reset wrong"); // [R2]

  property p_upperWrite;
    @(posedge mclk) disable iff (!resetn)
      regWrite && regAddr == mfp_pkg::OFS_MON_UPPER |=> upperLimit == $past(regWdata);
  endproperty
  a_upperWrite: assert property (p_upperWrite) else $error("monitor upper limit not written"); // [R3]

  property p_lowerReadBack;
    @(posedge mclk) disable iff (!resetn)
      !regWrite && regAddr == mfp_pkg::OFS_MON_LOWER |=> regRdata == lowerLimit;
  endproperty
  a_lowerReadBack: assert property (p_lowerReadBack) else $error("monitor lower limit read wrong"); // [R4]

  property p_shortOff;
    @(posedge mclk) disable iff (!resetn)
      pinSync[mfp_pkg::PIN_SHORT] && respCtrl[mfp_pkg::BIT_OFF_SHORT] && !respCtrl[mfp_pkg::BIT_SHORT_DIS]
      |=> biasFaultOff && !biasEnable;
  endproperty
  a_shortOff: assert property (p_shortOff) else $error("short fault did not power bias down"); // [R5]

  property p_highOff;
    @(posedge mclk) disable iff (!resetn)
      highCurrentFault && respCtrl[mfp_pkg::BIT_OFF_HIGH] |=> biasFaultOff;
  endproperty
  a_highOff: assert property (p_highOff) else $error("high-current fault did not power down"); // [R6]

  property p_lowOff;
    @(posedge mclk) disable iff (!resetn)
      lowCurrentFault && respCtrl[mfp_pkg::BIT_OFF_LOW] |=> biasFaultOff;
  endproperty
  a_lowOff: assert property (p_lowOff) else $error("low-current fault did not power down"); // [R7]

  property p_ovOff;
    @(posedge mclk) disable iff (!resetn)
      pinSync[mfp_pkg::PIN_OV] && respCtrl[mfp_pkg::BIT_OFF_OV] |=> biasFaultOff;
  endproperty
  a_ovOff: assert property (p_ovOff) else $error("overvoltage fault did not power down"); // [R8]

  property p_otOff;
    @(posedge mclk) disable iff (!resetn)
      pinSync[mfp_pkg::PIN_OT] && respCtrl[mfp_pkg::BIT_OFF_OT] |=> biasFaultOff;
  endproperty
  a_otOff: assert property (p_otOff) else $error("over-temperature fault did not power down"); // [R9]

  property p_manualSelfClear;
    @(posedge mclk) disable iff (!resetn)
      respCtrl[mfp_pkg::BIT_MAN_RECOV] && !(regWrite && regAddr == mfp_pkg::OFS_RESP_CTRL)
      |=> !respCtrl[mfp_pkg::BIT_MAN_RECOV];
  endproperty
  a_manualSelfClear: assert property (p_manualSelfClear) else $error("manual recovery bit stuck"); // [R10]

  property p_autoRecover;
    @(posedge mclk) disable iff (!resetn)
      biasFaultOff && !offRequest && respCtrl[mfp_pkg::BIT_AUTO_RECOV] && biasRequest |=> !biasFaultOff && biasEnable;
  endproperty
  a_autoRecover: assert property (p_autoRecover) else $error("auto recovery did not repower bias"); // [R11]

  property p_stayOff;
    @(posedge mclk) disable iff (!resetn)
      biasFaultOff && !respCtrl[mfp_pkg::BIT_AUTO_RECOV] && !respCtrl[mfp_pkg::BIT_MAN_RECOV] |=> biasFaultOff;
  endproperty
  a_stayOff: assert property (p_stayOff) else $error("bias recovered without a request"); // [R11]

  property p_shortMasked;
    @(posedge mclk) disable iff (!resetn)
      respCtrl[mfp_pkg::BIT_SHORT_DIS] && !regWrite && regAddr == mfp_pkg::OFS_FLT_STATUS
      |=> !regRdata[mfp_pkg::STS_SHORT];
  endproperty
  a_shortMasked: assert property (p_shortMasked) else $error("short reported while detection disabled"); // [R12]

  property p_highCompare;
    @(posedge mclk) disable iff (!resetn)
      sampleValid && biasLoadCode > highLimit |=> highCurrentFault;
  endproperty
  a_highCompare: assert property (p_highCompare) else $error("high-current fault missed"); // [R13]

  property p_monLowCompare;
    @(posedge mclk) disable iff (!resetn)
      sampleValid && !(monitorCode < lowerLimit) |=> !monitorLowFault;
  endproperty
  a_monLowCompare: assert property (p_monLowCompare) else $error("monitor low fault false"); // [R13]

endmodule

`default_nettype wire

// file: mfp_pkg.sv
package mfp_pkg;

  // register map of the bias fault supervision block
  localparam logic [7:0] OFS_HIGH_CUR   = 8'h4c;
  localparam logic [7:0] OFS_LOW_CUR    = 8'h4d;
  localparam logic [7:0] OFS_MON_UPPER  = 8'h4e;
  localparam logic [7:0] OFS_MON_LOWER  = 8'h4f;
  localparam logic [7:0] OFS_RESP_CTRL  = 8'h50;
  localparam logic [7:0] OFS_FLT_STATUS = 8'h5f;

  // reset values
  localparam logic [7:0] RST_HIGH_CUR   = 8'ha2;
  localparam logic [7:0] RST_LOW_CUR    = 8'h48;
  localparam logic [7:0] RST_MON_UPPER  = 8'hba;
  localparam logic [7:0] RST_MON_LOWER  = 8'h4b;
  localparam logic [7:0] RST_RESP_CTRL  = 8'h88;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // response control field positions
  localparam int BIT_OFF_SHORT  = 7;
  localparam int BIT_OFF_HIGH   = 6;
  localparam int BIT_OFF_LOW    = 5;
  localparam int BIT_OFF_OV     = 4;
  localparam int BIT_OFF_OT     = 3;
  localparam int BIT_MAN_RECOV  = 2;
  localparam int BIT_AUTO_RECOV = 1;
  localparam int BIT_SHORT_DIS  = 0;

  // fault status field positions
  localparam int STS_SHORT      = 7;
  localparam int STS_HIGH_CUR   = 6;
  localparam int STS_LOW_CUR    = 5;
  localparam int STS_OV         = 4;
  localparam int STS_OT         = 3;
  localparam int STS_MON_HIGH   = 2;
  localparam int STS_MON_LOW    = 1;
  localparam int STS_BIAS_OFF   = 0;

  // fault pins brought through the synchroniser
  localparam int PIN_SHORT      = 0;
  localparam int PIN_OV         = 1;
  localparam int PIN_OT         = 2;
  localparam int PIN_COUNT      = 3;

endpackage

// file: mfp_limit_check.sv
`timescale 1ns/100ps
`default_nettype none

// registered window comparison of one measurement against two limits
module mfp_limit_check (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       sampleValid,
  input  wire logic [7:0] code,
  input  wire logic [7:0] upperLimit,
  input  wire logic [7:0] lowerLimit,
  output var  logic       aboveLimit,
  output var  logic       belowLimit
);

  logic next_aboveLimit;
  logic next_belowLimit;

  // flags hold their last verdict between samples
  always_comb begin
    next_aboveLimit = aboveLimit;
    next_belowLimit = belowLimit;
    if (sampleValid) begin
      next_aboveLimit = code > upperLimit;  // strictly above  [R13]
      next_belowLimit = code < lowerLimit;  // strictly below  [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aboveLimit <= 1'b0;
      belowLimit <= 1'b0;
    end else begin
      aboveLimit <= next_aboveLimit;
      belowLimit <= next_belowLimit;
    end
  end

endmodule

`default_nettype wire

// file: tb_mfp_fault_protect.sv
`timescale 1ns/100ps
`default_nettype none

module tb_mfp_fault_protect;
  logic       mclk;
  logic       resetn;
  logic       regWrite;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       biasRequest;
  logic       sampleValid;
  logic [7:0] biasLoadCode;
  logic [7:0] monitorCode;
  logic       shortFaultPin;
  logic       overvoltagePin;
  logic       overtempPin;
  logic       biasEnable;
  logic       biasFaultOff;
  logic       highCurrentFault;
  logic       lowCurrentFault;
  logic       monitorHighFault;
  logic       monitorLowFault;
  int         fails;
  int         checksDone;
  logic [7:0] bitMask;

  // {load code, monitor code, expected {high, low, monHigh, monLow}} around limits 0x60/0x20/0x70/0x10
  localparam logic [19:0] WINDOW_CASES [8] = '{20'h60400, 20'h61408, 20'h20400, 20'h1f404,
                                               20'h40700, 20'h40712, 20'h40100, 20'h400f1};

  mfp_fault_protect u_dut (
    .mclk             (mclk),
    .resetn           (resetn),
    .regWrite         (regWrite),
    .regAddr          (regAddr),
    .regWdata         (regWdata),
    .regRdata         (regRdata),
    .biasRequest      (biasRequest),
    .sampleValid      (sampleValid),
    .biasLoadCode     (biasLoadCode),
    .monitorCode      (monitorCode),
    .shortFaultPin    (shortFaultPin),
    .overvoltagePin   (overvoltagePin),
    .overtempPin      (overtempPin),
    .biasEnable       (biasEnable),
    .biasFaultOff     (biasFaultOff),
    .highCurrentFault (highCurrentFault),
    .lowCurrentFault  (lowCurrentFault),
    .monitorHighFault (monitorHighFault),
    .monitorLowFault  (monitorLowFault)
  );

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // all stimulus moves on the falling edge, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, data held through the taking edge; the idle cycle after it
  // keeps back-to-back calls from dropping and raising the strobe in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    @(negedge mclk);
  endtask

  // read data is registered, so allow a full edge after the address settles
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    cyc(2);
    chk(regRdata, exp);
  endtask

  // one-cycle sample pulse; flags land one edge later, powerdown one more
  task automatic sample(input logic [7:0] ld, input logic [7:0] mon);
    biasLoadCode = ld;
    monitorCode = mon;
    sampleValid = 1'b1;
    @(negedge mclk);
    sampleValid = 1'b0;
    cyc(2);
  endtask

  // source 0 short pin, 1 high current, 2 low current, 3 overvoltage pin, 4 overtemp pin
  // pins need three edges, which the sample pulse plus one spare cycle covers
  task automatic fault(input int i, input logic on);
    shortFaultPin = on && i == 0;
    overvoltagePin = on && i == 3;
    overtempPin = on && i == 4;
    sample((on && i == 1) ? 8'hff : ((on && i == 2) ? 8'h00 : 8'h80), 8'h80);
    cyc(1);
  endtask

  task automatic stop_test;
    if (fails == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    checksDone = 0;
    bitMask = 8'h00;
    resetn = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    biasRequest = 1'b1;
    sampleValid = 1'b0;
    biasLoadCode = 8'h80;
    monitorCode = 8'h80;
    shortFaultPin = 1'b0;
    overvoltagePin = 1'b0;
    overtempPin = 1'b0;
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    // reset values, then writes to read-only and unmapped places are dropped
    rd_chk(mfp_pkg::OFS_HIGH_CUR, mfp_pkg::RST_HIGH_CUR);
    rd_chk(mfp_pkg::OFS_LOW_CUR, mfp_pkg::RST_LOW_CUR);
    rd_chk(mfp_pkg::OFS_MON_UPPER, mfp_pkg::RST_MON_UPPER);
    rd_chk(mfp_pkg::OFS_MON_LOWER, mfp_pkg::RST_MON_LOWER);
    rd_chk(mfp_pkg::OFS_RESP_CTRL, mfp_pkg::RST_RESP_CTRL);
    wr(mfp_pkg::OFS_FLT_STATUS, 8'hff);
    wr(8'h51, 8'hff);
    rd_chk(mfp_pkg::OFS_FLT_STATUS, 8'h00);
    rd_chk(8'h51, 8'h00);
    sample(8'h80, 8'h80);
    chk({7'h00, biasEnable}, 8'h01);
    // each source: no powerdown when its control is clear, latch when set, manual recovery after
    for (int i = 0; i < 5; i++) begin
      bitMask = 8'h80 >> i;
      wr(mfp_pkg::OFS_RESP_CTRL, 8'h00);
      fault(i, 1'b1);
      chk({6'h00, biasFaultOff, biasEnable}, 8'h01);
      rd_chk(mfp_pkg::OFS_FLT_STATUS, bitMask);
      fault(i, 1'b0);
      wr(mfp_pkg::OFS_RESP_CTRL, bitMask);
      fault(i, 1'b1);
      chk({6'h00, biasFaultOff, biasEnable}, 8'h02);
      rd_chk(mfp_pkg::OFS_FLT_STATUS, bitMask | 8'h01);
      fault(i, 1'b0);
      chk({6'h00, biasFaultOff, biasEnable}, 8'h02);
      wr(mfp_pkg::OFS_RESP_CTRL, bitMask | 8'h04);
      cyc(2);
      chk({6'h00, biasFaultOff, biasEnable}, 8'h01);
      rd_chk(mfp_pkg::OFS_RESP_CTRL, bitMask);
    end
    // manual recovery refused while the fault is still present
    wr(mfp_pkg::OFS_RESP_CTRL, 8'h08);
    fault(4, 1'b1);
    wr(mfp_pkg::OFS_RESP_CTRL, 8'h0c);
    cyc(2);
    chk({7'h00, biasFaultOff}, 8'h01);
    fault(4, 1'b0);
    // auto recovery returns the bias once the fault drops
    wr(mfp_pkg::OFS_RESP_CTRL, 8'h42);
    fault(1, 1'b1);
    chk({7'h00, biasFaultOff}, 8'h01);
    fault(1, 1'b0);
    chk({6'h00, biasFaultOff, biasEnable}, 8'h01);
    // short detection disabled: no powerdown and nothing reported
    wr(mfp_pkg::OFS_RESP_CTRL, 8'h81);
    fault(0, 1'b1);
    chk({7'h00, biasFaultOff}, 8'h00);
    rd_chk(mfp_pkg::OFS_FLT_STATUS, 8'h00);
    fault(0, 1'b0);
    // bias request low drops the enable on its own
    biasRequest = 1'b0;
    cyc(2);
    chk({7'h00, biasEnable}, 8'h00);
    biasRequest = 1'b1;
    // new limits, then strict compares at and just past each limit
    wr(mfp_pkg::OFS_RESP_CTRL, 8'h00);
    wr(mfp_pkg::OFS_HIGH_CUR, 8'h60);
    wr(mfp_pkg::OFS_LOW_CUR, 8'h20);
    wr(mfp_pkg::OFS_MON_UPPER, 8'h70);
    wr(mfp_pkg::OFS_MON_LOWER, 8'h10);
    rd_chk(mfp_pkg::OFS_HIGH_CUR, 8'h60);
    rd_chk(mfp_pkg::OFS_LOW_CUR, 8'h20);
    rd_chk(mfp_pkg::OFS_MON_UPPER, 8'h70);
    rd_chk(mfp_pkg::OFS_MON_LOWER, 8'h10);
    for (int k = 0; k < 8; k++) begin
      sample(WINDOW_CASES[k][19:12], WINDOW_CASES[k][11:4]);
      chk({4'h0, highCurrentFault, lowCurrentFault, monitorHighFault, monitorLowFault},
          {4'h0, WINDOW_CASES[k][3:0]});
    end
    // the last case leaves only the monitor low flag, which status must show too
    rd_chk(mfp_pkg::OFS_FLT_STATUS, 8'h02);
    // a second reset mid-run brings written limits back to their defaults
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(1);
    rd_chk(mfp_pkg::OFS_HIGH_CUR, mfp_pkg::RST_HIGH_CUR);
    rd_chk(mfp_pkg::OFS_MON_LOWER, mfp_pkg::RST_MON_LOWER);
    chk({6'h00, biasFaultOff, biasEnable}, 8'h01);
    stop_test();
  end
endmodule

`default_nettype wire
